// >>> pcpc_pkg.sv
// package: register map and reset values for the port c pin configuration block
package pcpc_pkg;
	localparam int          PCPC_PIN_COUNT       = 8;
	localparam int          PCPC_ADDR_W          = 12;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PCPC_ANSEL_OFFSET    = 12'h000;
	localparam logic [11:0] PCPC_PULLUP_OFFSET   = 12'h004;
	localparam logic [11:0] PCPC_OPTION_OFFSET   = 12'h008;
	localparam logic [11:0] PCPC_DIR_OFFSET      = 12'h00C;
	localparam logic [11:0] PCPC_STATUS_OFFSET   = 12'h010;
	// ----------------------------------------------------------------
	// reset values and implemented-bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  PCPC_ANSEL_RESET     = 8'hFF;
	localparam logic [7:0]  PCPC_PULLUP_RESET    = 8'hFF;
	localparam logic [7:0]  PCPC_DIR_RESET       = 8'hFF;
	localparam logic        PCPC_PU_DIS_N_RESET  = 1'h1;
	localparam logic [7:0]  PCPC_ANSEL_MASK_BASE = 8'h0F;
	localparam logic [7:0]  PCPC_UPPER_PAIR_MASK = 8'hC0;
	localparam logic [7:0]  PCPC_PULLUP_MASK_BASE = 8'h3F;
	localparam int          PCPC_PU_DIS_BIT      = 0;
	localparam logic [31:0] PCPC_READ_ZERO       = 32'h0000_0000;
endpackage

// >>> pcpc_sync.sv
// three-stage input synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module pcpc_sync
	import pcpc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output var  logic dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;

	// stage chain; output changes once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end

	assign dout = out_q;
endmodule
`default_nettype wire

// >>> pcpc_pin_cell.sv
// per-pin input gating and pull-up qualification
`timescale 1ns/10ps
`default_nettype none
module pcpc_pin_cell
	import pcpc_pkg::*;
(
	input  wire logic analog_sel,
	input  wire logic pullup_bit,
	input  wire logic pullup_dis_n,
	input  wire logic dir_input,
	input  wire logic pin_sync,
	output var  logic dig_in,
	output var  logic buf_en,
	output var  logic analog_en,
	output var  logic pullup_on
);
	// digital buffer on only in digital mode, forced low in analog mode
	assign buf_en    = ~analog_sel;
	assign dig_in    = pin_sync & ~analog_sel;
	assign analog_en = analog_sel;
	// pull-up needs its bit, global enable low and pin as input
	assign pullup_on = pullup_bit & ~pullup_dis_n & dir_input;
endmodule
`default_nettype wire

// >>> pcpc_top.sv
// port c pin configuration block: apb registers, analog select and pull-ups
`timescale 1ns/10ps
`default_nettype none
module pcpc_top
	import pcpc_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1,
	parameter int PINS          = PCPC_PIN_COUNT
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PCPC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	input  wire logic [PINS-1:0]       port_c_pins_in,
	output var  logic [PINS-1:0]       port_c_pins_dig_in,
	output var  logic [PINS-1:0]       port_c_pins_buf_en,
	output var  logic [PINS-1:0]       port_c_pins_analog_en,
	output var  logic [PINS-1:0]       port_c_pins_pullup_en,
	output var  logic [PINS-1:0]       pin_direction_bit
);
	// ----------------------------------------------------------------
	// implemented-bit masks per package variant
	// ----------------------------------------------------------------
	// constant masks so the reset branch assigns constants only
	localparam logic [7:0] ANSEL_IMPL  = LARGE_PACKAGE ? (PCPC_ANSEL_MASK_BASE | PCPC_UPPER_PAIR_MASK)
	                                                   : PCPC_ANSEL_MASK_BASE;
	localparam logic [7:0] PULLUP_IMPL = LARGE_PACKAGE ? (PCPC_PULLUP_MASK_BASE | PCPC_UPPER_PAIR_MASK)
	                                                   : PCPC_PULLUP_MASK_BASE;
	wire logic [7:0] ansel_mask;
	wire logic [7:0] pullup_mask;
	assign ansel_mask  = ANSEL_IMPL;
	assign pullup_mask = PULLUP_IMPL;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic [7:0] ansel_q;
	logic [7:0] pullup_q;
	logic [7:0] dir_q;
	logic       pu_dis_n_q;
	logic [31:0] prdata_q;

	wire logic access_ph;
	wire logic wr_en;
	wire logic rd_en;
	wire logic hit_ansel;
	wire logic hit_pullup;
	wire logic hit_option;
	wire logic hit_dir;
	wire logic hit_status;
	wire logic hit_any;
	wire logic lane0;
	assign access_ph  = psel & penable;
	assign hit_ansel  = (paddr == PCPC_ANSEL_OFFSET);
	assign hit_pullup = (paddr == PCPC_PULLUP_OFFSET);
	assign hit_option = (paddr == PCPC_OPTION_OFFSET);
	assign hit_dir    = (paddr == PCPC_DIR_OFFSET);
	assign hit_status = (paddr == PCPC_STATUS_OFFSET);
	assign hit_any    = hit_ansel | hit_pullup | hit_option | hit_dir | hit_status;
	assign lane0      = pstrb[0];
	assign wr_en      = access_ph & pwrite & hit_any & lane0;
	assign rd_en      = access_ph & ~pwrite;

	// zero-wait slave; unmapped address and status write report error
	assign pready  = 1'b1;
	assign pslverr = access_ph & (~hit_any | (pwrite & hit_status));

	// ----------------------------------------------------------------
	// pin synchronisers and per-pin cells
	// ----------------------------------------------------------------
	logic [PINS-1:0] pin_sync;
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			pcpc_sync u_sync (
				.pclk    (pclk),
				.presetn (presetn),
				.din     (port_c_pins_in[gi]),
				.dout    (pin_sync[gi])
			);
			pcpc_pin_cell u_cell (
				.analog_sel   (ansel_q[gi]),
				.pullup_bit   (pullup_q[gi]),
				.pullup_dis_n (pu_dis_n_q),
				.dir_input    (dir_q[gi]),
				.pin_sync     (pin_sync[gi]),
				.dig_in       (port_c_pins_dig_in[gi]),
				.buf_en       (port_c_pins_buf_en[gi]),
				.analog_en    (port_c_pins_analog_en[gi]),
				.pullup_on    (port_c_pins_pullup_en[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// register write path
	// ----------------------------------------------------------------
	// masked writes keep unimplemented positions at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ansel_q    <= PCPC_ANSEL_RESET & ANSEL_IMPL;
			pullup_q   <= PCPC_PULLUP_RESET & PULLUP_IMPL;
			dir_q      <= PCPC_DIR_RESET;
			pu_dis_n_q <= PCPC_PU_DIS_N_RESET;
		end else if (wr_en) begin
			if (hit_ansel) begin
				ansel_q <= pwdata[7:0] & ansel_mask;
			end
			if (hit_pullup) begin
				pullup_q <= pwdata[7:0] & pullup_mask;
			end
			if (hit_option) begin
				pu_dis_n_q <= pwdata[PCPC_PU_DIS_BIT];
			end
			if (hit_dir) begin
				dir_q <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire logic [7:0]  status_view;
	wire logic [31:0] rd_mux;
	assign status_view = port_c_pins_pullup_en;
	assign rd_mux = hit_ansel  ? {24'h000000, ansel_q & ansel_mask} :
	                hit_pullup ? {24'h000000, pullup_q & pullup_mask} :
	                hit_option ? {31'h00000000, pu_dis_n_q} :
	                hit_dir    ? {24'h000000, dir_q} :
	                hit_status ? {24'h000000, status_view} : PCPC_READ_ZERO;

	// registered read data, captured at the setup-phase edge (psel high, penable low)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= PCPC_READ_ZERO;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata            = rd_en ? prdata_q : PCPC_READ_ZERO;
	assign pin_direction_bit = dir_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ansel_mid_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ansel_q[5:4] == 2'b00) else $error("analog select bits 5..4 not zero");
	a_ansel_small_pkg: assert property (@(posedge pclk) disable iff (!presetn)
		!LARGE_PACKAGE |-> ansel_q[7:6] == 2'b00) else $error("analog upper pair set");
	a_pullup_small_pkg: assert property (@(posedge pclk) disable iff (!presetn)
		!LARGE_PACKAGE |-> pullup_q[7:6] == 2'b00) else $error("pull-up upper pair set");
	a_analog_buf_off: assert property (@(posedge pclk) disable iff (!presetn)
		(port_c_pins_buf_en & ansel_q) == '0) else $error("buffer on in analog mode");
	a_digital_path_on: assert property (@(posedge pclk) disable iff (!presetn)
		(port_c_pins_buf_en | ansel_q) == '1) else $error("buffer off in digital mode");
	a_global_pullup_off: assert property (@(posedge pclk) disable iff (!presetn)
		pu_dis_n_q |-> port_c_pins_pullup_en == '0) else $error("pull-up on while disabled");
	a_output_no_pullup: assert property (@(posedge pclk) disable iff (!presetn)
		(port_c_pins_pullup_en & ~dir_q) == '0) else $error("pull-up on output pin");
	a_pullup_follows: assert property (@(posedge pclk) disable iff (!presetn)
		!pu_dis_n_q |-> port_c_pins_pullup_en == (pullup_q & dir_q)) else $error("pull-up mismatch");
	a_ansel_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_ansel |=> ansel_q == ($past(pwdata[7:0]) & ansel_mask))
		else $error("analog select write lost");
	a_read_masked: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && hit_pullup |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");

	a_dig_in_gated: assert property (@(posedge pclk) disable iff (!presetn)
		(port_c_pins_dig_in & ansel_q) == '0) else $error("digital input seen on analog pin");
	a_bad_addr_err: assert property (@(posedge pclk) disable iff (!presetn)
		access_ph && !hit_any |-> pslverr) else $error("unmapped access without error");
	a_pullup_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_pullup |=> pullup_q == ($past(pwdata[7:0]) & pullup_mask))
		else $error("pull-up write lost");

	c_analog_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_ansel);
	c_pullup_active: cover property (@(posedge pclk) disable iff (!presetn) port_c_pins_pullup_en != '0);
	c_bad_address: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule
`default_nettype wire

// >>> test_port_c_pin_config.sv
// testbench for the port c pin configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module test_port_c_pin_config
	import pcpc_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observation signals
	// ----------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  pins_in = 8'h00;
	logic [7:0]  dig_in;
	logic [7:0]  buf_en;
	logic [7:0]  analog_en;
	logic [7:0]  pullup_en;
	logic [7:0]  dir_bits;
	int          error_cnt = 0;
	int          check_count = 0;
	int          cycles = 0;
	// rows: analog wr, pullup wr, option wr, dir wr, analog rd, pullup rd, analog_en, pullup_en
	logic [63:0] rows [4] = '{64'hFF_FF_00_FF_CF_FF_CF_FF, 64'h00_A5_00_0F_00_A5_00_05,
	                          64'h35_3C_01_FF_05_3C_05_00, 64'hC0_5A_00_F3_C0_5A_C0_52};

	pcpc_top #(.LARGE_PACKAGE(1'b1), .PINS(8)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_c_pins_in(pins_in), .port_c_pins_dig_in(dig_in),
		.port_c_pins_buf_en(buf_en), .port_c_pins_analog_en(analog_en),
		.port_c_pins_pullup_en(pullup_en), .pin_direction_bit(dir_bits)
	);

	// clock and hang guard
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// apb master tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
	                   output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, {24'h00_0000, d}, rd, err);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		`CHK(rd, e)
		`CHK(err, ee)
	endtask

	// reset values seen through the bus and the pins
	task automatic reset_chk();
		rd_chk(PCPC_ANSEL_OFFSET, 32'h0000_00CF, 1'b0);
		rd_chk(PCPC_PULLUP_OFFSET, 32'h0000_00FF, 1'b0);
		`CHK(pullup_en, 8'h00)
		`CHK(buf_en, 8'h30)
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [63:0] r;
		int          n;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		reset_chk();
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			r = rows[i];
			wr(PCPC_ANSEL_OFFSET, r[63:56]);
			wr(PCPC_PULLUP_OFFSET, r[55:48]);
			wr(PCPC_OPTION_OFFSET, r[47:40]);
			wr(PCPC_DIR_OFFSET, r[39:32]);
			rd_chk(PCPC_ANSEL_OFFSET, {24'h00_0000, r[31:24]}, 1'b0);
			rd_chk(PCPC_PULLUP_OFFSET, {24'h00_0000, r[23:16]}, 1'b0);
			`CHK(analog_en, r[15:8])
			`CHK(buf_en, ~r[15:8])
			`CHK(pullup_en, r[7:0])
			`CHK(dir_bits, r[39:32])
			$display("test row %0d done", i);
		end
		// digital input follows the pin only where the pin is digital
		wr(PCPC_DIR_OFFSET, 8'hFF);
		wr(PCPC_ANSEL_OFFSET, 8'h0F);
		pins_in <= 8'hA5;
		n = 0;
		while (dig_in !== 8'hA0 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		`CHK(dig_in, 8'hA0)
		$display("test digital input done");
		// unmapped place, status write and a write without strobe
		rd_chk(12'h020, 32'h0000_0000, 1'b1);
		apb(1'b1, PCPC_STATUS_OFFSET, 32'h0000_00FF, r[31:0], r[32]);
		`CHK(r[32], 1'b1)
		pstrb <= 4'h0;
		wr(PCPC_ANSEL_OFFSET, 8'hC0);
		pstrb <= 4'hF;
		rd_chk(PCPC_ANSEL_OFFSET, 32'h0000_000F, 1'b0);
		$display("test refused writes done");
		// second reset in mid-run
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		reset_chk();
		$display("test second reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
